// [shared/nvs_pkg.sv]
/*
  Constants shared by the nonvolatile access sequencer: the map of the
  device registers reached over the device bus, the control bit layout
  and the map of the software port. Assumes one clock domain.
*/
package nvs_pkg;

  // Device register map on the device bus
  localparam logic [7:0] DEV_CELL_INDEX_ADDR    = 8'h10;
  localparam logic [7:0] DEV_CELL_BYTE_ADDR     = 8'h11;
  localparam logic [7:0] DEV_POINTER_LOW_ADDR   = 8'h03;
  localparam logic [7:0] DEV_POINTER_HIGH_ADDR  = 8'h04;
  localparam logic [7:0] DEV_INDIRECT_PORT_ADDR = 8'h02;
  localparam logic [7:0] DEV_IRQ_CTRL_ADDR      = 8'h0E;

  // Pointer values that select nv_control in sector 1, and the sector 0 value that deselects it
  localparam logic [7:0] NV_CONTROL_PTR_LOW  = 8'h40;
  localparam logic [7:0] NV_CONTROL_SECTOR   = 8'h01;
  localparam logic [7:0] SECTOR0_SELECT      = 8'h00;

  // nv_control bit positions and clear value, plus the IRQ control gate bit and the cell index width
  localparam int FETCH_GO_BIT       = 0;
  localparam int FETCH_PERMIT_BIT   = 1;
  localparam int PROG_GO_BIT        = 2;
  localparam int PROG_PERMIT_BIT    = 3;
  localparam int GLOBAL_IRQ_GATE_BIT = 0;
  localparam int CELL_INDEX_W       = 5;
  localparam logic [7:0] NV_CONTROL_CLEAR = 8'h00;

  // Software port offsets
  localparam logic [3:0] SW_CTRL_OFS     = 4'h0;
  localparam logic [3:0] SW_ADDR_OFS     = 4'h1;
  localparam logic [3:0] SW_WDATA_OFS    = 4'h2;
  localparam logic [3:0] SW_RDATA_OFS    = 4'h3;
  localparam logic [3:0] SW_STATUS_OFS   = 4'h4;
  localparam logic [3:0] SW_IRQ_STAT_OFS = 4'h5;
  localparam logic [3:0] SW_IRQ_MASK_OFS = 4'h6;

  // CTRL fields
  localparam int CTRL_START_READ_BIT  = 0;
  localparam int CTRL_START_WRITE_BIT = 1;
  localparam int CTRL_VERIFY_BIT      = 2;
  localparam logic CTRL_VERIFY_RST    = 1'b0;

  // Event bits, shared by IRQ status and mask
  localparam int EV_W            = 4;
  localparam int EV_READ_DONE    = 0;
  localparam int EV_WRITE_DONE   = 1;
  localparam int EV_VERIFY_FAIL  = 2;
  localparam int EV_TIMEOUT      = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // Polls of a busy start bit before giving up
  localparam int POLL_LIMIT_DEF = 65536;

  typedef enum logic [3:0] {
    NVS_IDLE   = 4'h0,
    NVS_W_IDX  = 4'h1,
    NVS_W_DAT  = 4'h3,
    NVS_W_PLO  = 4'h2,
    NVS_W_PHI  = 4'h6,
    NVS_W_GOFF = 4'h7,
    NVS_W_PERM = 4'h5,
    NVS_W_GO   = 4'h4,
    NVS_W_GON  = 4'hC,
    NVS_POLL   = 4'hD,
    NVS_CLRCTL = 4'hF,
    NVS_CLRPHI = 4'hE,
    NVS_R_DATA = 4'hA,
    NVS_FINISH = 4'hB
  } nvs_state_type;

endpackage

// [shared/nvs_acc_if.sv]
/*
  Carrier between the sequencer and its device bus engine: one access
  request with its answer. Assumes both ends on core_clk.
*/
`timescale 1ns/100ps
interface nvs_acc_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ready;
  logic       rdone;
  logic [7:0] rdata;

  modport seq (output req, output wr, output addr, output wdata,
               input ready, input rdone, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output ready, output rdone, output rdata);
endinterface

// [rtl/nvs_acc_eng.sv]
/*
  Device bus engine: turns one accepted request into a one-cycle strobe
  on the device bus. Write data and read strobes leave from flip-flops.
  Assumes the device answers a read in the cycle after its strobe.
*/
`timescale 1ns/100ps
module nvs_acc_eng (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  nvs_acc_if.eng          acc,
  output logic [7:0]      dev_addr,
  output logic [7:0]      dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata
);

  logic       wr_r,   wr_nxt;
  logic       rd_r,   rd_nxt;
  logic       wait_r, wait_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic       take;

  // A read blocks new requests until its answer is back
  assign acc.ready = !rd_r && !wait_r;
  assign take      = acc.req && acc.ready;
  assign acc.rdone = wait_r;
  assign acc.rdata = dev_rdata;

  always_comb begin
    wr_nxt   = take && acc.wr;
    rd_nxt   = take && !acc.wr;
    wait_nxt = rd_r;
    addr_nxt = take ? acc.addr : addr_r;
    data_nxt = take ? acc.wdata : data_r;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      wait_r <= 1'b0;
      addr_r <= 8'h00;
      data_r <= 8'h00;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      wait_r <= wait_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
    end
  end

  assign dev_wr    = wr_r;
  assign dev_rd    = rd_r;
  assign dev_addr  = addr_r;
  assign dev_wdata = data_r;

endmodule

// [rtl/nvs_host.sv]
/*
  Host sequencer for single-byte reads and writes of a 32 x 8 data store
  reached through address, data, pointer and indirect registers of the
  device. Software orders transfers through a small register port.
  Assumes the device bus and software port run on core_clk.
*/
`timescale 1ns/100ps
module nvs_host #(
  parameter int POLL_LIMIT = nvs_pkg::POLL_LIMIT_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  output logic            irq,
  input  wire logic       sleep_req,
  output logic            sleep_ok,
  output logic [7:0]      dev_addr,
  output logic [7:0]      dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata
);

  if (POLL_LIMIT < 1 || POLL_LIMIT > 32'h00FF_FFFF) begin : g_chk
    $error("POLL_LIMIT out of range");
  end

  nvs_acc_if acc ();

  nvs_acc_eng u_eng (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .acc       (acc.eng),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .dev_rdata (dev_rdata)
  );

  localparam int IW = nvs_pkg::CELL_INDEX_W;
  localparam int EW = nvs_pkg::EV_W;

  nvs_pkg::nvs_state_type state_r, state_nxt;
  logic          op_wr_r,   op_wr_nxt;
  logic          vphase_r,  vphase_nxt;
  logic          pend_r,    pend_nxt;
  logic          tmo_r,     tmo_nxt;
  logic [23:0]   poll_r,    poll_nxt;
  logic [IW-1:0] index_r,   index_nxt;
  logic [7:0]    wbyte_r,   wbyte_nxt;
  logic [7:0]    rbyte_r,   rbyte_nxt;
  logic          verify_r,  verify_nxt;
  logic [EW-1:0] stat_r,    stat_nxt;
  logic [EW-1:0] mask_r,    mask_nxt;
  logic [7:0]    rdata_r,   rdata_nxt;
  logic [EW-1:0] ev;
  logic          ack;
  logic          go_busy;
  logic [7:0]    permit_val;
  logic [7:0]    go_val;
  logic          start_rd;
  logic          start_wr;
  logic          ctrl_wr;

  assign ack     = acc.req && acc.ready;
  assign ctrl_wr = sw_wr && (sw_addr == nvs_pkg::SW_CTRL_OFS);
  // Starts are refused while busy or while a power-down is pending
  assign start_rd = ctrl_wr && sw_wdata[nvs_pkg::CTRL_START_READ_BIT]
                    && (state_r == nvs_pkg::NVS_IDLE) && !sleep_req;
  // Write wins if software sets both start bits in one access
  assign start_wr = ctrl_wr && sw_wdata[nvs_pkg::CTRL_START_WRITE_BIT]
                    && (state_r == nvs_pkg::NVS_IDLE) && !sleep_req;

  // Only one permit and one go bit per op, never both go bits
  always_comb begin
    permit_val = 8'h00;
    go_val     = 8'h00;
    if (op_wr_r) begin
      permit_val[nvs_pkg::PROG_PERMIT_BIT] = 1'b1;
      go_val[nvs_pkg::PROG_PERMIT_BIT]     = 1'b1;
      go_val[nvs_pkg::PROG_GO_BIT]         = 1'b1;
    end else begin
      permit_val[nvs_pkg::FETCH_PERMIT_BIT] = 1'b1;
      go_val[nvs_pkg::FETCH_PERMIT_BIT]     = 1'b1;
      go_val[nvs_pkg::FETCH_GO_BIT]         = 1'b1;
    end
  end

  // Device clears the go bit itself at the end of its cycle
  assign go_busy = op_wr_r ? acc.rdata[nvs_pkg::PROG_GO_BIT]
                           : acc.rdata[nvs_pkg::FETCH_GO_BIT];

  always_comb begin
    state_nxt  = state_r;
    op_wr_nxt  = op_wr_r;
    vphase_nxt = vphase_r;
    pend_nxt   = pend_r;
    tmo_nxt    = tmo_r;
    poll_nxt   = poll_r;
    rbyte_nxt  = rbyte_r;
    ev         = '0;
    acc.req    = 1'b0;
    acc.wr     = 1'b1;
    acc.addr   = nvs_pkg::DEV_INDIRECT_PORT_ADDR;
    acc.wdata  = nvs_pkg::NV_CONTROL_CLEAR;
    case (state_r)
      nvs_pkg::NVS_IDLE: begin
        if (start_rd || start_wr) begin
          op_wr_nxt  = start_wr;
          vphase_nxt = 1'b0;
          tmo_nxt    = 1'b0;
          state_nxt  = nvs_pkg::NVS_W_IDX;
        end
      end
      nvs_pkg::NVS_W_IDX: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_CELL_INDEX_ADDR;
        acc.wdata = {{(8-IW){1'b0}}, index_r};
        if (ack) begin
          state_nxt = op_wr_r ? nvs_pkg::NVS_W_DAT : nvs_pkg::NVS_W_PLO;
        end
      end
      nvs_pkg::NVS_W_DAT: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_CELL_BYTE_ADDR;
        acc.wdata = wbyte_r;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_W_PLO;
        end
      end
      nvs_pkg::NVS_W_PLO: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_POINTER_LOW_ADDR;
        acc.wdata = nvs_pkg::NV_CONTROL_PTR_LOW;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_W_PHI;
        end
      end
      nvs_pkg::NVS_W_PHI: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_POINTER_HIGH_ADDR;
        acc.wdata = nvs_pkg::NV_CONTROL_SECTOR;
        if (ack) begin
          state_nxt = op_wr_r ? nvs_pkg::NVS_W_GOFF : nvs_pkg::NVS_W_PERM;
        end
      end
      nvs_pkg::NVS_W_GOFF: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_IRQ_CTRL_ADDR;
        acc.wdata = 8'h00;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_W_PERM;
        end
      end
      nvs_pkg::NVS_W_PERM: begin
        acc.req   = 1'b1;
        acc.wdata = permit_val;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_W_GO;
        end
      end
      nvs_pkg::NVS_W_GO: begin
        // The engine stalls a request only behind a read, so this strobe follows the
        // permit write strobe in the very next cycle
        acc.req   = 1'b1;
        acc.wdata = go_val;
        if (ack) begin
          poll_nxt  = '0;
          pend_nxt  = 1'b0;
          state_nxt = op_wr_r ? nvs_pkg::NVS_W_GON : nvs_pkg::NVS_POLL;
        end
      end
      nvs_pkg::NVS_W_GON: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_IRQ_CTRL_ADDR;
        acc.wdata = 8'h00;
        acc.wdata[nvs_pkg::GLOBAL_IRQ_GATE_BIT] = 1'b1;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_POLL;
        end
      end
      nvs_pkg::NVS_POLL: begin
        acc.req = !pend_r;
        acc.wr  = 1'b0;
        if (ack) begin
          pend_nxt = 1'b1;
        end
        if (acc.rdone) begin
          pend_nxt = 1'b0;
          if (!go_busy) begin
            state_nxt = nvs_pkg::NVS_CLRCTL;
          end else if (poll_r == 24'(POLL_LIMIT - 1)) begin
            tmo_nxt   = 1'b1;
            state_nxt = nvs_pkg::NVS_CLRCTL;
          end else begin
            poll_nxt = poll_r + 24'h00_0001;
          end
        end
      end
      nvs_pkg::NVS_CLRCTL: begin
        acc.req   = 1'b1;
        acc.wdata = nvs_pkg::NV_CONTROL_CLEAR;
        if (ack) begin
          state_nxt = nvs_pkg::NVS_CLRPHI;
        end
      end
      nvs_pkg::NVS_CLRPHI: begin
        acc.req   = 1'b1;
        acc.addr  = nvs_pkg::DEV_POINTER_HIGH_ADDR;
        acc.wdata = nvs_pkg::SECTOR0_SELECT;
        if (ack) begin
          if (tmo_r) begin
            state_nxt = nvs_pkg::NVS_FINISH;
          end else if (!op_wr_r) begin
            pend_nxt  = 1'b0;
            state_nxt = nvs_pkg::NVS_R_DATA;
          end else if (verify_r) begin
            op_wr_nxt  = 1'b0;
            vphase_nxt = 1'b1;
            state_nxt  = nvs_pkg::NVS_W_IDX;
          end else begin
            state_nxt = nvs_pkg::NVS_FINISH;
          end
        end
      end
      nvs_pkg::NVS_R_DATA: begin
        acc.req  = !pend_r;
        acc.wr   = 1'b0;
        acc.addr = nvs_pkg::DEV_CELL_BYTE_ADDR;
        if (ack) begin
          pend_nxt = 1'b1;
        end
        if (acc.rdone) begin
          pend_nxt  = 1'b0;
          rbyte_nxt = acc.rdata;
          state_nxt = nvs_pkg::NVS_FINISH;
        end
      end
      nvs_pkg::NVS_FINISH: begin
        if (tmo_r) begin
          ev[nvs_pkg::EV_TIMEOUT] = 1'b1;
        end else if (vphase_r) begin
          ev[nvs_pkg::EV_WRITE_DONE]  = 1'b1;
          ev[nvs_pkg::EV_VERIFY_FAIL] = (rbyte_r != wbyte_r);
        end else if (op_wr_r) begin
          ev[nvs_pkg::EV_WRITE_DONE] = 1'b1;
        end else begin
          ev[nvs_pkg::EV_READ_DONE] = 1'b1;
        end
        state_nxt = nvs_pkg::NVS_IDLE;
      end
      default: begin
        state_nxt = nvs_pkg::NVS_IDLE;
      end
    endcase
  end

  // Software registers; status read clears, a same-cycle event wins
  always_comb begin
    index_nxt  = index_r;
    wbyte_nxt  = wbyte_r;
    verify_nxt = verify_r;
    mask_nxt   = mask_r;
    stat_nxt   = stat_r;
    rdata_nxt  = 8'h00;
    if (ctrl_wr) begin
      verify_nxt = sw_wdata[nvs_pkg::CTRL_VERIFY_BIT];
    end
    if (sw_wr && sw_addr == nvs_pkg::SW_ADDR_OFS && state_r == nvs_pkg::NVS_IDLE) begin
      index_nxt = sw_wdata[IW-1:0];
    end
    if (sw_wr && sw_addr == nvs_pkg::SW_WDATA_OFS && state_r == nvs_pkg::NVS_IDLE) begin
      wbyte_nxt = sw_wdata;
    end
    if (sw_wr && sw_addr == nvs_pkg::SW_IRQ_MASK_OFS) begin
      mask_nxt = sw_wdata[EW-1:0];
    end
    if (sw_rd) begin
      case (sw_addr)
        nvs_pkg::SW_CTRL_OFS: begin
          rdata_nxt[nvs_pkg::CTRL_VERIFY_BIT] = verify_r;
        end
        nvs_pkg::SW_ADDR_OFS:     rdata_nxt = {{(8-IW){1'b0}}, index_r};
        nvs_pkg::SW_WDATA_OFS:    rdata_nxt = wbyte_r;
        nvs_pkg::SW_RDATA_OFS:    rdata_nxt = rbyte_r;
        nvs_pkg::SW_STATUS_OFS:   rdata_nxt = {7'h00, state_r != nvs_pkg::NVS_IDLE};
        nvs_pkg::SW_IRQ_STAT_OFS: rdata_nxt = {{(8-EW){1'b0}}, stat_r};
        nvs_pkg::SW_IRQ_MASK_OFS: rdata_nxt = {{(8-EW){1'b0}}, mask_r};
        default:                  rdata_nxt = 8'h00;
      endcase
      if (sw_addr == nvs_pkg::SW_IRQ_STAT_OFS) begin
        stat_nxt = '0;
      end
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r  <= nvs_pkg::NVS_IDLE;
      op_wr_r  <= 1'b0;
      vphase_r <= 1'b0;
      pend_r   <= 1'b0;
      tmo_r    <= 1'b0;
      poll_r   <= '0;
      rbyte_r  <= 8'h00;
      index_r  <= '0;
      wbyte_r  <= 8'h00;
      verify_r <= nvs_pkg::CTRL_VERIFY_RST;
      mask_r   <= nvs_pkg::IRQ_MASK_RST;
      stat_r   <= '0;
      rdata_r  <= 8'h00;
    end else begin
      state_r  <= state_nxt;
      op_wr_r  <= op_wr_nxt;
      vphase_r <= vphase_nxt;
      pend_r   <= pend_nxt;
      tmo_r    <= tmo_nxt;
      poll_r   <= poll_nxt;
      rbyte_r  <= rbyte_nxt;
      index_r  <= index_nxt;
      wbyte_r  <= wbyte_nxt;
      verify_r <= verify_nxt;
      mask_r   <= mask_nxt;
      stat_r   <= stat_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign sw_rdata = rdata_r;
  assign irq      = |(stat_r & mask_r);
  // Power-down only allowed once every device access is over
  assign sleep_ok = (state_r == nvs_pkg::NVS_IDLE);

endmodule

// [verification/nvs_host_checker.sv]
/*
  Port assertions for the nonvolatile host sequencer.
  Assumes it is bound onto nvs_host and that everything runs on core_clk.
*/
`timescale 1ns/100ps
module nvs_chk (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic       sw_wr,
  input wire logic       sw_rd,
  input wire logic [7:0] sw_rdata,
  input wire logic       irq,
  input wire logic       sleep_req,
  input wire logic       sleep_ok,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic       dev_wr,
  input wire logic       dev_rd,
  input wire logic [7:0] dev_rdata
);
  localparam logic [7:0] A_IND = nvs_pkg::DEV_INDIRECT_PORT_ADDR;
  localparam logic [7:0] A_PHI = nvs_pkg::DEV_POINTER_HIGH_ADDR;
  logic [7:0] plo_r, phi_r, gate_r, ind_r, plo_nxt, phi_nxt, gate_nxt, ind_nxt;
  logic       fresh_r, fresh_nxt, wr_ind, start;
  assign wr_ind = dev_wr && dev_addr == A_IND;
  assign start  = sw_wr && sw_addr == nvs_pkg::SW_CTRL_OFS && sw_wdata[1:0] != 2'h0;
  // Shadow of what the sequencer has written into the device
  always_comb begin
    plo_nxt   = plo_r;
    phi_nxt   = phi_r;
    gate_nxt  = gate_r;
    ind_nxt   = ind_r;
    fresh_nxt = fresh_r;
    if (dev_wr) begin
      case (dev_addr)
        nvs_pkg::DEV_POINTER_LOW_ADDR: plo_nxt = dev_wdata;
        A_PHI: phi_nxt = dev_wdata;
        nvs_pkg::DEV_IRQ_CTRL_ADDR: gate_nxt = dev_wdata;
        nvs_pkg::DEV_CELL_INDEX_ADDR: fresh_nxt = 1'b1;
        A_IND: begin
          ind_nxt = dev_wdata;
          if (dev_wdata[0]) fresh_nxt = 1'b0;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {plo_r, phi_r, gate_r, ind_r, fresh_r} <= '0;
    end else begin
      {plo_r, phi_r, gate_r, ind_r, fresh_r} <= {plo_nxt, phi_nxt, gate_nxt, ind_nxt, fresh_nxt};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_read_gap; dev_rd |=> !dev_rd && !dev_wr; endproperty
  a_read_gap: assert property (p_read_gap) else $error("device access right after a read");
  property p_go_next; wr_ind && dev_wdata[2] |-> $past(wr_ind) && $past(dev_wdata) == 8'h08;
  endproperty
  a_go_next: assert property (p_go_next) else $error("write go not right after permit");
  property p_gate_off; wr_ind && dev_wdata[2] |-> !gate_r[0]; endproperty
  a_gate_off: assert property (p_gate_off) else $error("write go with irq gate open");
  property p_refused; start && sleep_req && sleep_ok |=> sleep_ok; endproperty
  a_refused: assert property (p_refused) else $error("start taken during sleep request");
  property p_taken; start && !sleep_req && sleep_ok |=> !sleep_ok [*4]; endproperty
  a_taken: assert property (p_taken) else $error("start did not leave idle");
  property p_fresh; wr_ind && dev_wdata[0] |-> fresh_r; endproperty
  a_fresh: assert property (p_fresh) else $error("fetch go without index reload");
  property p_ptr; wr_ind || (dev_rd && dev_addr == A_IND) |-> plo_r == 8'h40 && phi_r == 8'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("control access with wrong pointers");
  property p_fetch_order; wr_ind && dev_wdata[0] |-> ind_r == 8'h02; endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("fetch go without permit");
  property p_clr_order;
    wr_ind && dev_wdata == 8'h00 |=> ##[0:3] dev_wr && dev_addr == A_PHI && dev_wdata == 8'h00;
  endproperty
  a_clr_order: assert property (p_clr_order) else $error("pointer high not cleared");
  property p_idle_safe; sleep_ok |-> phi_nxt == 8'h00 && !ind_nxt[3]; endproperty
  a_idle_safe: assert property (p_idle_safe) else $error("idle with permit or sector set");
  property p_one_go; wr_ind |-> !(dev_wdata[0] && dev_wdata[2]); endproperty
  a_one_go: assert property (p_one_go) else $error("both go bits together");
  c_write: cover property (wr_ind && dev_wdata[2]);
  c_fetch: cover property (wr_ind && dev_wdata[0]);
  c_refused: cover property (start && sleep_req && sleep_ok);
endmodule

bind nvs_host nvs_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .sw_addr(sw_addr),
  .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
  .sleep_req(sleep_req), .sleep_ok(sleep_ok), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));

// [verification/nvs_dev_model.sv]
/*
  Behavioural model of the device with its 32 x 8 data store.
  Assumes reads are answered in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module nvs_dev_model #(
  parameter int WR_CYC   = 6,
  parameter int SLOW_CYC = 60
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  output logic [7:0]      dev_rdata,
  input  wire logic       slow,
  output logic            viol
);
  logic [7:0] mem_r [32];
  logic [4:0] idx_r;
  logic [7:0] byte_r, plo_r, phi_r, gate_r, q_r, tmr_r, rval;
  logic [3:0] ctl_r;
  logic       vld_r, done_r, perm_prev_r, sel;
  assign sel = plo_r == 8'h40 && phi_r == 8'h01;
  always_comb begin
    case (dev_addr)
      nvs_pkg::DEV_CELL_INDEX_ADDR: rval = {3'h0, idx_r};
      nvs_pkg::DEV_CELL_BYTE_ADDR: rval = byte_r;
      nvs_pkg::DEV_INDIRECT_PORT_ADDR: rval = sel ? {4'h0, ctl_r} : 8'h00;
      default: rval = 8'h00;
    endcase
  end
  // Off-answer cycles show the inverse so a stale sample cannot pass
  assign dev_rdata = vld_r ? q_r : ~q_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) mem_r[i] <= 8'hC0 | 8'(i);
      {idx_r, byte_r, plo_r, phi_r, gate_r, q_r, tmr_r, ctl_r} <= '0;
      {vld_r, done_r, perm_prev_r, viol} <= '0;
    end else begin
      vld_r <= dev_rd;
      if (dev_rd) q_r <= rval;
      perm_prev_r <= dev_wr && dev_addr == nvs_pkg::DEV_INDIRECT_PORT_ADDR && sel && dev_wdata[3];
      if (ctl_r[0]) ctl_r[0] <= 1'b0;
      if (ctl_r[2]) begin
        tmr_r <= tmr_r - 8'h01;
        if (tmr_r == 8'h01) begin
          ctl_r[2] <= 1'b0;
          mem_r[idx_r] <= byte_r;
          done_r <= 1'b1;
        end
      end
      if (dev_wr) begin
        case (dev_addr)
          nvs_pkg::DEV_CELL_INDEX_ADDR: idx_r <= dev_wdata[4:0];
          nvs_pkg::DEV_CELL_BYTE_ADDR: byte_r <= dev_wdata;
          nvs_pkg::DEV_POINTER_LOW_ADDR: plo_r <= dev_wdata;
          nvs_pkg::DEV_POINTER_HIGH_ADDR: phi_r <= dev_wdata;
          nvs_pkg::DEV_IRQ_CTRL_ADDR: gate_r <= dev_wdata;
          nvs_pkg::DEV_INDIRECT_PORT_ADDR: if (sel) begin
            ctl_r[3] <= dev_wdata[3];
            ctl_r[1] <= dev_wdata[1];
            // Go bits are set only over a permit already in place
            if (dev_wdata[2] && ctl_r[3] && !ctl_r[2]) begin
              ctl_r[2] <= 1'b1;
              tmr_r <= slow ? 8'(SLOW_CYC) : 8'(WR_CYC);
            end
            if (dev_wdata[0] && ctl_r[1]) begin
              ctl_r[0] <= 1'b1;
              byte_r <= mem_r[idx_r];
            end
            if (dev_wdata[2] && (!perm_prev_r || gate_r[0])) viol <= 1'b1;
            if (dev_wdata[0] && dev_wdata[2]) viol <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// [verification/tb.sv]
/*
  Self-checking bench for nvs_host with the device model on its bus.
  Assumes the software port answers reads in the cycle after the strobe.
*/
`timescale 1ns/100ps
module tb;
  logic       core_clk, sys_rst, sw_wr, sw_rd, sleep_req, sleep_ok, irq, slow, viol;
  logic       dev_wr, dev_rd;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, dev_addr, dev_wdata, dev_rdata, rd_v;
  int         n_errors = 0;
  int         compares = 0;
  nvs_host #(.POLL_LIMIT(8)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
    .sleep_req(sleep_req), .sleep_ok(sleep_ok), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  nvs_dev_model dev_u (.core_clk(core_clk), .sys_rst(sys_rst), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
    .slow(slow), .viol(viol));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 rd_v = sw_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      rd(nvs_pkg::SW_STATUS_OFS);
      if (rd_v[0] === 1'b0) break;
    end
    chk(rd_v, 8'h00);
  endtask
  task automatic t_reset();
    // Look once the release has settled, not in the releasing time step
    #1 chk({5'h0, irq, sleep_ok, sw_rdata[0]}, 8'h02);
    chk({6'h0, dev_wr, dev_rd}, 8'h00);
    rdc(nvs_pkg::SW_IRQ_MASK_OFS, 8'h00);
    rdc(nvs_pkg::SW_CTRL_OFS, 8'h00);
    rdc(4'h7, 8'h00);
  endtask
  task automatic do_write(input logic [4:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(nvs_pkg::SW_ADDR_OFS, {3'h0, a});
    wr(nvs_pkg::SW_WDATA_OFS, d);
    wr(nvs_pkg::SW_CTRL_OFS, c);
    #1 chk({7'h0, sleep_ok}, 8'h00);
    // An index change while busy must not reach the running transfer
    wr(nvs_pkg::SW_ADDR_OFS, {3'h0, ~a});
    wait_idle();
    rdc(nvs_pkg::SW_ADDR_OFS, {3'h0, a});
    chk(dev_u.mem_r[a], d);
    chk(dev_u.phi_r, 8'h00);
    chk({3'h0, dev_u.ctl_r[3], 3'h0, viol}, 8'h00);
  endtask
  task automatic t_write_irq();
    wr(nvs_pkg::SW_IRQ_MASK_OFS, 8'h02);
    // Both start bits at once: the write is the one that runs
    do_write(5'h1F, 8'hA5, 8'h03);
    chk({7'h0, irq}, 8'h01);
    rdc(nvs_pkg::SW_IRQ_STAT_OFS, 8'h02);
    chk({7'h0, irq}, 8'h00);
    rdc(nvs_pkg::SW_IRQ_STAT_OFS, 8'h00);
    wr(nvs_pkg::SW_IRQ_MASK_OFS, 8'h00);
  endtask
  task automatic t_read(input logic [4:0] a, input logic [7:0] exp);
    wr(nvs_pkg::SW_ADDR_OFS, {3'h0, a});
    wr(nvs_pkg::SW_CTRL_OFS, 8'h01);
    wait_idle();
    rdc(nvs_pkg::SW_RDATA_OFS, exp);
    rdc(nvs_pkg::SW_IRQ_STAT_OFS, 8'h01);
  endtask
  task automatic t_verify();
    wr(nvs_pkg::SW_CTRL_OFS, 8'h04);
    do_write(5'h00, 8'h3C, 8'h06);
    rd(nvs_pkg::SW_IRQ_STAT_OFS);
    chk(rd_v & 8'h06, 8'h02);
    rdc(nvs_pkg::SW_CTRL_OFS, 8'h04);
    wr(nvs_pkg::SW_CTRL_OFS, 8'h00);
  endtask
  task automatic t_sleep();
    @(posedge core_clk);
    sleep_req <= 1'b1;
    wr(nvs_pkg::SW_CTRL_OFS, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, sleep_ok}, 8'h01);
    rdc(nvs_pkg::SW_STATUS_OFS, 8'h00);
    sleep_req <= 1'b0;
  endtask
  task automatic t_timeout();
    @(posedge core_clk);
    slow <= 1'b1;
    wr(nvs_pkg::SW_ADDR_OFS, 8'h05);
    wr(nvs_pkg::SW_WDATA_OFS, 8'h77);
    wr(nvs_pkg::SW_CTRL_OFS, 8'h02);
    wait_idle();
    chk({7'h0, irq}, 8'h00);
    rd(nvs_pkg::SW_IRQ_STAT_OFS);
    chk(rd_v & 8'h08, 8'h08);
    chk(dev_u.phi_r, 8'h00);
    repeat (80) @(posedge core_clk);
    slow <= 1'b0;
    chk(dev_u.mem_r[5], 8'h77);
  endtask
  initial begin
    sys_rst = 1'b1;
    {sw_wr, sw_rd, sleep_req, slow} = 4'h0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_write_irq();
    t_read(5'h1F, 8'hA5);
    t_read(5'h1E, 8'hDE);
    t_verify();
    t_sleep();
    t_timeout();
    complete_run();
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
endmodule
